// file: rtl/tx_link_pkg.sv
package tx_link_pkg;
  localparam int LANES   = 2;
  localparam int CONVS   = 2;
  localparam int WORD_W  = 32;
  localparam int OCTETS  = 4;
  localparam int ADDR_W  = 12;

  // Control symbols (8-bit value, sent with the K flag)
  localparam logic [7:0] SYM_K28_5 = 8'hbc;
  localparam logic [7:0] SYM_K28_0 = 8'h1c;
  localparam logic [7:0] SYM_K28_3 = 8'h7c;

  localparam logic [ADDR_W-1:0] ADDR_CTRL = 12'h000;
  localparam logic [ADDR_W-1:0] ADDR_CFG  = 12'h004;
  localparam logic [ADDR_W-1:0] ADDR_STAT = 12'h008;

  localparam int CTRL_LANE_SYNC_EN = 0;
  localparam int CTRL_SUBCLASS_LSB = 1;
  localparam int CTRL_LINK_RST     = 3;
  localparam logic [31:0] CTRL_RESET = 32'h0000_0009;

  localparam int CFG_MF_LEN_LSB    = 0;
  localparam int CFG_FRAME_LEN_LSB = 8;
  localparam int CFG_ILAS_MF_LSB   = 16;
  localparam logic [31:0] CFG_RESET = 32'h0000_000f;

  localparam int STAT_STATE_LSB = 0;
  localparam int STAT_SYNC_LSB  = 2;
  localparam int STAT_READY     = 4;

  localparam logic [8:0] ILAS_MF_BASE = 9'h004;
  localparam logic [7:0] OCTET_STEP   = 8'h04;
  localparam logic [1:0] SUBCLASS_0   = 2'h0;

  typedef enum logic [1:0] {ST_CGS, ST_ILAS, ST_DATA} link_state_t;
endpackage

// file: rtl/lmfc_if.sv
`timescale 1ns/1ps
interface lmfc_if;
  logic [7:0] mf_len_m1;
  logic [7:0] frame_len_m1;
  logic       frame_start;
  logic       mf_start;

  modport ctl
  (
    output mf_len_m1,
    output frame_len_m1,
    input  frame_start,
    input  mf_start
  );
  modport cnt
  (
    input  mf_len_m1,
    input  frame_len_m1,
    output frame_start,
    output mf_start
  );
endinterface

// file: rtl/sync_stage.sv
`timescale 1ns/1ps
module sync_stage
#(
  parameter int WIDTH = 1
)
(
  input  wire logic             pclk,
  input  wire logic             presetn,
  input  wire logic [WIDTH-1:0] async_in,
  output logic      [WIDTH-1:0] sync_out
);
  logic [WIDTH-1:0] meta_reg;

  // Idle level of a request line is high (released is high)
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      meta_reg <= '0;
      sync_out <= '0;
    end
    else
    begin
      meta_reg <= async_in;
      sync_out <= meta_reg;
    end
  end
endmodule

// file: rtl/lmfc_counter.sv
`timescale 1ns/1ps
module lmfc_counter
(
  input  wire logic pclk,
  input  wire logic presetn,
  lmfc_if.cnt       lm
);
  logic [7:0] mf_pos_reg;
  logic [7:0] fr_pos_reg;

  // Positions are counted in link cycles, four octets each
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      mf_pos_reg <= '0;
      fr_pos_reg <= '0;
    end
    else if (mf_pos_reg >= lm.mf_len_m1)
    begin
      mf_pos_reg <= '0;
      fr_pos_reg <= '0;
    end
    else
    begin
      mf_pos_reg <= mf_pos_reg + 8'h01;
      fr_pos_reg <= (fr_pos_reg >= lm.frame_len_m1) ? 8'h00 : fr_pos_reg + 8'h01;
    end
  end

  assign lm.mf_start    = (mf_pos_reg == 8'h00);
  assign lm.frame_start = (fr_pos_reg == 8'h00);
endmodule

// file: rtl/tx_link_sync.sv
// Summary of operation
// [RL1] Each lane carries one 32-bit four-octet word
// [RL2] Link logic advances one four-symbol word per cycle
// [RL3] Multiframe length must be whole words
// [RL4] Frame and multiframe counters count link cycles
// [RL5] Source streams continuously; no backpressure offered
// [RL6] Register accesses are whole 32-bit words
// [RL7] Asynchronous inputs are synchronised before use
// [RL8] Software configures before releasing link reset
// [RL9] Writes zero wait; reads one wait
// [RL10] Bring-up: commas, then alignment (skipped in subclass 0 with lane sync off), then data
// [RL11] Commas on all lanes while sync requested
// [RL12] Converter locks after four consecutive commas
// [RL13] Leave commas only when all requests released
// [RL14] Subclass 0 leaves at next frame start
// [RL15] Subclass 1/2 leaves at next multiframe boundary
// [RL16] No option to delay alignment start
// [RL17] Alignment lasts four multiframes, subclass 0 extendable
// [RL18] Alignment multiframe: K28.0, counter fill, K28.3
// [RL19] Renewed sync request restarts from commas
// [RL20] Link reset holds and restarts comma phase
`timescale 1ns/1ps
module tx_link_sync
  import tx_link_pkg::*;
(
  input  wire logic                                pclk,
  input  wire logic                                presetn,
  input  wire logic                                psel,
  input  wire logic                                penable,
  input  wire logic                                pwrite,
  input  wire logic [tx_link_pkg::ADDR_W-1:0]      paddr,
  input  wire logic [31:0]                         pwdata,
  output logic      [31:0]                         prdata,
  output logic                                     pready,
  output logic                                     pslverr,
  input  wire logic [tx_link_pkg::CONVS-1:0]       sync_n,
  input  wire logic [tx_link_pkg::LANES*32-1:0]    in_data,
  input  wire logic                                in_valid,
  output logic      [tx_link_pkg::LANES*32-1:0]    lane_data,
  output logic      [tx_link_pkg::LANES*4-1:0]     lane_k,
  output logic                                     link_ready
);
  import tx_link_pkg::*;

  logic [31:0]       ctrl_reg;
  logic [31:0]       cfg_reg;
  logic              rd_wait_reg;
  link_state_t       state_reg;
  logic [7:0]        ilas_pos_reg;
  logic [8:0]        ilas_mf_reg;
  logic [7:0]        dummy_reg;
  logic [CONVS-1:0]  sync_s;
  logic              released;
  logic              lane_sync_en;
  logic [1:0]        subclass;
  logic              link_rst;
  logic [8:0]        ilas_ext;
  logic [8:0]        ilas_total;
  logic              mf_last;
  logic              ilas_done;
  logic              addr_ok;
  logic              wr_take;
  logic [31:0]       rd_mux;
  logic [LANES*32-1:0] data_next;
  logic [LANES*4-1:0]  k_next;

  lmfc_if lm ();

  sync_stage #(.WIDTH(CONVS)) u_sync
  (
    .pclk     (pclk),
    .presetn  (presetn),
    .async_in (sync_n),
    .sync_out (sync_s)
  ); // see [RL7]

  lmfc_counter u_lmfc
  (
    .pclk    (pclk),
    .presetn (presetn),
    .lm      (lm.cnt)
  ); // see [RL4]

  assign lane_sync_en    = ctrl_reg[CTRL_LANE_SYNC_EN];
  assign subclass        = ctrl_reg[CTRL_SUBCLASS_LSB +: 2];
  assign link_rst        = ctrl_reg[CTRL_LINK_RST];
  assign lm.mf_len_m1    = cfg_reg[CFG_MF_LEN_LSB +: 8];
  assign lm.frame_len_m1 = cfg_reg[CFG_FRAME_LEN_LSB +: 8];
  assign released        = &sync_s; // see [RL13]

  // APB slave
  assign addr_ok = (paddr == ADDR_CTRL) || (paddr == ADDR_CFG) || (paddr == ADDR_STAT);
  assign wr_take = psel && penable && pwrite && pready;

  always_comb
  begin
    rd_mux = 32'h0000_0000;
    unique case (paddr)
      ADDR_CTRL: rd_mux = ctrl_reg;
      ADDR_CFG:  rd_mux = cfg_reg;
      ADDR_STAT:
      begin
        rd_mux[STAT_STATE_LSB +: 2] = state_reg;
        rd_mux[STAT_SYNC_LSB +: 2]  = sync_s;
        rd_mux[STAT_READY]          = link_ready;
      end
      default:   rd_mux = 32'h0000_0000;
    endcase
  end

  // Write answers in the first access cycle, read in the second
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      pready      <= 1'b0;
      pslverr     <= 1'b0;
      prdata      <= '0;
      rd_wait_reg <= 1'b0;
    end
    else if (pready)
    begin
      pready      <= 1'b0;
      pslverr     <= 1'b0;
      rd_wait_reg <= 1'b0;
    end
    else if (psel && !penable && pwrite)
    begin
      pready  <= 1'b1; // see [RL9]
      pslverr <= !addr_ok;
    end
    else if (psel && penable && !pwrite && !rd_wait_reg)
    begin
      rd_wait_reg <= 1'b1;
      pready      <= 1'b1; // see [RL9]
      pslverr     <= !addr_ok;
      prdata      <= rd_mux; // see [RL6]
    end
  end

  // Whole-word writes only; unmapped writes are dropped with an error
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      ctrl_reg <= CTRL_RESET;
      cfg_reg  <= CFG_RESET;
    end
    else if (wr_take && paddr == ADDR_CTRL)
    begin
      ctrl_reg <= pwdata; // see [RL6]
    end
    else if (wr_take && paddr == ADDR_CFG)
    begin
      cfg_reg <= pwdata;
    end
  end

  // Alignment length: four multiframes, longer only in subclass 0
  assign ilas_ext   = {1'b0, cfg_reg[CFG_ILAS_MF_LSB +: 8]} + 9'h001;
  assign ilas_total = (subclass == SUBCLASS_0 && ilas_ext > ILAS_MF_BASE) ?
                      ilas_ext : ILAS_MF_BASE; // see [RL17]
  assign mf_last    = (ilas_pos_reg >= lm.mf_len_m1);
  assign ilas_done  = mf_last && (ilas_mf_reg == ilas_total - 9'h001);

  // Link state: commas, alignment, data
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      state_reg <= ST_CGS;
    end
    else if (link_rst || !released)
    begin
      state_reg <= ST_CGS; // see [RL19] see [RL20]
    end
    else
    begin
      unique case (state_reg)
        ST_CGS:
        begin
          if (subclass == SUBCLASS_0 && lm.frame_start)
          begin
            state_reg <= lane_sync_en ? ST_ILAS : ST_DATA; // see [RL14]
          end
          else if (subclass != SUBCLASS_0 && lm.mf_start)
          begin
            state_reg <= ST_ILAS; // see [RL15] see [RL16]
          end
        end
        ST_ILAS:
        begin
          if (ilas_done)
          begin
            state_reg <= ST_DATA; // see [RL10]
          end
        end
        ST_DATA: state_reg <= ST_DATA;
      endcase
    end
  end

  // Alignment position counters are held at zero outside alignment
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      ilas_pos_reg <= '0;
      ilas_mf_reg  <= '0;
      dummy_reg    <= '0;
    end
    else if (state_reg != ST_ILAS || link_rst || !released)
    begin
      ilas_pos_reg <= '0;
      ilas_mf_reg  <= '0;
      dummy_reg    <= '0;
    end
    else
    begin
      dummy_reg    <= dummy_reg + OCTET_STEP;
      ilas_pos_reg <= mf_last ? 8'h00 : ilas_pos_reg + 8'h01;
      ilas_mf_reg  <= mf_last ? ilas_mf_reg + 9'h001 : ilas_mf_reg;
    end
  end

  // Octet 0 of a word sits in bits [7:0] and leaves first
  genvar gl;
  genvar go;
  generate
    for (gl = 0; gl < LANES; gl++)
    begin : g_lane
      for (go = 0; go < OCTETS; go++)
      begin : g_oct
        always_comb
        begin
          data_next[gl*32 + go*8 +: 8] = SYM_K28_5; // see [RL11]
          k_next[gl*4 + go]            = 1'b1;
          unique case (state_reg)
            ST_CGS:
            begin
              data_next[gl*32 + go*8 +: 8] = SYM_K28_5;
              k_next[gl*4 + go]            = 1'b1;
            end
            ST_ILAS:
            begin
              if (go == 0 && ilas_pos_reg == 8'h00)
              begin
                data_next[gl*32 + go*8 +: 8] = SYM_K28_0; // see [RL18]
                k_next[gl*4 + go]            = 1'b1;
              end
              else if (go == OCTETS-1 && mf_last)
              begin
                data_next[gl*32 + go*8 +: 8] = SYM_K28_3; // see [RL18]
                k_next[gl*4 + go]            = 1'b1;
              end
              else
              begin
                data_next[gl*32 + go*8 +: 8] = dummy_reg + 8'(go);
                k_next[gl*4 + go]            = 1'b0;
              end
            end
            ST_DATA:
            begin
              data_next[gl*32 + go*8 +: 8] = in_data[gl*32 + go*8 +: 8]; // see [RL1]
              k_next[gl*4 + go]            = 1'b0;
            end
          endcase
        end
      end
    end
  endgenerate

  // One word per lane per cycle; in_valid is informational only
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      lane_data  <= {LANES*OCTETS{SYM_K28_5}};
      lane_k     <= '1;
      link_ready <= 1'b0;
    end
    else
    begin
      lane_data  <= data_next; // see [RL2] see [RL5]
      lane_k     <= k_next;
      link_ready <= (state_reg == ST_DATA);
    end
  end

  chk_cgs_comma: assert property (@(posedge pclk) disable iff (!presetn)
    state_reg == ST_CGS |=> lane_data == {LANES*OCTETS{SYM_K28_5}} && lane_k == '1)
    else $error("comma not sent during sync phase"); // see [RL11]

  chk_write_no_wait: assert property (@(posedge pclk) disable iff (!presetn)
    psel && !penable && pwrite && !pready |=> pready)
    else $error("write not answered without wait"); // see [RL9]

  chk_read_one_wait: assert property (@(posedge pclk) disable iff (!presetn)
    psel && !penable && !pwrite && !pready |=> !pready ##1 pready)
    else $error("read not answered after one wait"); // see [RL9]

  chk_link_rst_hold: assert property (@(posedge pclk) disable iff (!presetn)
    link_rst |=> state_reg == ST_CGS)
    else $error("link reset did not hold comma phase"); // see [RL20]

  chk_all_released: assert property (@(posedge pclk) disable iff (!presetn)
    state_reg == ST_CGS && !released |=> state_reg == ST_CGS)
    else $error("left comma phase with a request pending"); // see [RL13]

  chk_sc12_mf_start: assert property (@(posedge pclk) disable iff (!presetn)
    state_reg == ST_CGS && subclass != SUBCLASS_0 && released && !link_rst &&
    lm.mf_start |=> state_reg == ST_ILAS)
    else $error("alignment not started at multiframe boundary"); // see [RL15]

  chk_sc12_no_early: assert property (@(posedge pclk) disable iff (!presetn)
    state_reg == ST_CGS && subclass != SUBCLASS_0 && !lm.mf_start |=> state_reg == ST_CGS)
    else $error("comma phase left off a multiframe boundary"); // see [RL16]

  chk_sc0_frame: assert property (@(posedge pclk) disable iff (!presetn)
    state_reg == ST_CGS && subclass == SUBCLASS_0 && released && !link_rst &&
    lm.frame_start |=> state_reg == (lane_sync_en ? ST_ILAS : ST_DATA))
    else $error("subclass 0 exit wrong at frame start"); // see [RL14]

  chk_resync: assert property (@(posedge pclk) disable iff (!presetn)
    state_reg != ST_CGS && !released |=> state_reg == ST_CGS ##1 lane_k == '1)
    else $error("renewed request did not restart commas"); // see [RL19]

  chk_ilas_start: assert property (@(posedge pclk) disable iff (!presetn)
    state_reg == ST_ILAS && ilas_pos_reg == 8'h00 |=> lane_k[0] && lane_data[7:0] == SYM_K28_0)
    else $error("alignment multiframe did not open with K28.0"); // see [RL18]

  chk_ilas_end: assert property (@(posedge pclk) disable iff (!presetn) // see [RL18]
    state_reg == ST_ILAS && mf_last |=> lane_k[3] && lane_data[31:24] == SYM_K28_3)
    else $error("alignment multiframe did not close with K28.3");

  chk_ilas_length: assert property (@(posedge pclk) disable iff (!presetn) // see [RL17]
    state_reg == ST_ILAS |-> ilas_mf_reg < ilas_total)
    else $error("alignment phase ran past its multiframe count");

  chk_data_pass: assert property (@(posedge pclk) disable iff (!presetn) // see [RL1]
    state_reg == ST_DATA |=> lane_data == $past(in_data) && lane_k == '0)
    else $error("user data not passed through unchanged");

  chk_ready_follows: assert property (@(posedge pclk) disable iff (!presetn) // see [RL10]
    1'b1 |=> link_ready == $past(state_reg == ST_DATA))
    else $error("link ready does not follow the data phase");

  chk_unmapped_err: assert property (@(posedge pclk) disable iff (!presetn) // see [RL6]
    psel && penable && pready && !addr_ok |-> pslverr)
    else $error("unmapped access answered without error");
endmodule

// file: sim/dac_model.sv
`timescale 1ns/1ps
module dac_model
(
  input  wire logic                             pclk,
  input  wire logic                             presetn,
  input  wire logic [tx_link_pkg::LANES*32-1:0] lane_data,
  input  wire logic [tx_link_pkg::LANES*4-1:0]  lane_k,
  input  wire logic [tx_link_pkg::CONVS-1:0]    hold_req,
  output logic      [tx_link_pkg::CONVS-1:0]    sync_n
);
  import tx_link_pkg::*;
  // Converter c listens to lane c; a whole comma word is four K symbols
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      sync_n <= '0;
    else
      for (int c = 0; c < CONVS; c++)
        if (hold_req[c])
          sync_n[c] <= 1'b0;
        else if (lane_k[4*c+:4] == 4'hf && lane_data[32*c+:32] == {4{SYM_K28_5}})
          sync_n[c] <= 1'b1;
  end
endmodule

// file: sim/tx_link_sync_tb.sv
`timescale 1ns/1ps
module tx_link_sync_tb;
  import tx_link_pkg::*;
  logic              pclk = 1'b0;
  logic              presetn = 1'b0;
  logic              psel = 1'b0;
  logic              penable = 1'b0;
  logic              pwrite = 1'b0;
  logic [ADDR_W-1:0] paddr = '0;
  logic [31:0]       pwdata = '0;
  logic [31:0]       prdata;
  logic              pready;
  logic              pslverr;
  logic [CONVS-1:0]  sync_n;
  logic [CONVS-1:0]  hold_req = '1;
  logic [63:0]       in_data = '0;
  logic [63:0]       prev_in = '0;
  logic              in_valid = 1'b1;
  logic [63:0]       lane_data;
  logic [7:0]        lane_k;
  logic              link_ready;
  logic [15:0]       seed = 16'h003b;
  logic [31:0]       rd;
  logic              err;
  int                fails = 0;
  int                checks = 0;
  localparam logic [71:0] COMMAS = {8'hff, {8{SYM_K28_5}}};

  always #5 pclk = ~pclk;

  tx_link_sync dut
  (
    .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .sync_n(sync_n), .in_data(in_data), .in_valid(in_valid), .lane_data(lane_data),
    .lane_k(lane_k), .link_ready(link_ready)
  );
  dac_model peer
  (
    .pclk(pclk), .presetn(presetn), .lane_data(lane_data), .lane_k(lane_k),
    .hold_req(hold_req), .sync_n(sync_n)
  );

  function automatic logic [15:0] lfsr(input logic [15:0] s);
    return {s[14:0], s[15] ^ s[13] ^ s[12] ^ s[10]};
  endfunction

  // Octet j%4 of lane j/4 for alignment word w of multiframes m+1 words long
  function automatic logic [71:0] ilas_word(input int w, input logic [7:0] m);
    logic [7:0]  k;
    logic [63:0] d;
    for (int j = 0; j < 8; j++)
    begin
      d[8*j+:8] = 8'(4 * w + j % 4);
      k[j] = 1'b0;
      if (w % (m + 1) == 0 && j % 4 == 0)
        {k[j], d[8*j+:8]} = {1'b1, SYM_K28_0};
      if (w % (m + 1) == m && j % 4 == 3)
        {k[j], d[8*j+:8]} = {1'b1, SYM_K28_3};
    end
    return {k, d};
  endfunction

  // The source never pauses, since nothing can hold it back
  always @(posedge pclk)
  begin
    seed <= lfsr(seed);
    prev_in <= in_data;
    in_data <= {seed, ~seed, seed ^ 16'h5a5a, seed + 16'h1234};
  end

  task automatic finish_test();
    if (fails == 0 && checks > 0)
      $display("RESULT: PASS");
    else
      $display("RESULT: FAIL");
    $finish;
  endtask

  task automatic cmp_reg(input string name, input logic [31:0] exp, input logic [31:0] got);
    checks++;
    if (got !== exp)
    begin
      fails++;
      $display("Error %s expected %h seen %h", name, exp, got);
    end
  endtask

  task automatic cmp_lane(input string name, input logic [71:0] exp, input logic [71:0] got);
    checks++;
    if (got !== exp)
    begin
      fails++;
      $display("Error %s expected %h seen %h", name, exp, got);
    end
  endtask

  task automatic apb(input logic w, input logic [ADDR_W-1:0] a, input logic [31:0] d);
    int n;
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    n = 0;
    do
    begin
      @(posedge pclk);
      n++;
    end
    while (pready !== 1'b1 && n < 50);
    rd = prdata;
    err = pslverr;
    cmp_reg("apb access cycles", w ? 1 : 2, n);
    if (n >= 50)
    begin
      fails++;
      finish_test();
    end
    psel <= 1'b0;
    penable <= 1'b0;
    @(posedge pclk);
  endtask

  task automatic bring_up(input logic [1:0] sc, input logic en, input logic [7:0] ilas_m1);
    logic [7:0] m;
    int         mfs;
    int         n;
    m = 8'(1 + seed % 7);
    mfs = (en && sc == SUBCLASS_0 && ilas_m1 > 3) ? ilas_m1 + 1 : 4;
    hold_req <= '1;
    apb(1'b1, ADDR_CTRL, 32'h0000_0008);
    apb(1'b1, ADDR_CFG, {8'h00, ilas_m1, 8'h00, m});
    hold_req <= '0;
    repeat (40) @(posedge pclk);
    cmp_lane("link reset lanes", COMMAS, {lane_k, lane_data});
    hold_req <= 2'b10;
    apb(1'b1, ADDR_CTRL, {28'h0, 1'b0, sc, en});
    repeat (40) @(posedge pclk);
    cmp_lane("one request held", COMMAS, {lane_k, lane_data});
    hold_req <= '0;
    n = 0;
    @(negedge pclk);
    while ({lane_k, lane_data} === COMMAS && n < 400)
    begin
      @(negedge pclk);
      n++;
    end
    cmp_reg("comma phase ended", 32'h1, {31'h0, n < 400});
    if (en || sc != SUBCLASS_0)
      for (int w = 0; w < mfs * (m + 1); w++)
      begin
        cmp_lane("alignment word", ilas_word(w, m), {lane_k, lane_data});
        @(negedge pclk);
      end
    cmp_lane("user data", {8'h00, prev_in}, {lane_k, lane_data});
    @(negedge pclk);
    cmp_reg("link ready", 32'h1, {31'h0, link_ready});
    @(posedge pclk);
    apb(1'b0, ADDR_STAT, '0);
    cmp_reg("status", 32'h0000_001e, rd & 32'h0000_001f);
    hold_req <= 2'b01;
    repeat (8) @(posedge pclk);
    @(negedge pclk);
    cmp_lane("renewed request", COMMAS, {lane_k, lane_data});
    cmp_reg("ready dropped", 32'h0, {31'h0, link_ready});
    @(posedge pclk);
  endtask

  initial
  begin
    repeat (2) @(posedge pclk);
    cmp_lane("reset lanes", COMMAS, {lane_k, lane_data});
    cmp_reg("reset ready", 32'h0, {31'h0, link_ready});
    presetn <= 1'b1;
    @(posedge pclk);
    apb(1'b0, ADDR_CTRL, '0);
    cmp_reg("control reset", CTRL_RESET, rd);
    apb(1'b0, ADDR_CFG, '0);
    cmp_reg("config reset", CFG_RESET, rd);
    apb(1'b1, 12'h0fc, 32'hffff_ffff);
    cmp_reg("unmapped write error", 32'h1, {31'h0, err});
    apb(1'b0, 12'h0fc, '0);
    cmp_reg("unmapped read data", 32'h0, rd);
    cmp_reg("unmapped read error", 32'h1, {31'h0, err});
    apb(1'b0, ADDR_CTRL, '0);
    cmp_reg("control kept", CTRL_RESET, rd);
    bring_up(SUBCLASS_0, 1'b1, 8'h03);
    bring_up(SUBCLASS_0, 1'b1, 8'h05);
    bring_up(SUBCLASS_0, 1'b0, 8'h00);
    bring_up(2'h1, 1'b1, 8'h07);
    bring_up(2'h2, 1'b0, 8'h07);
    finish_test();
  end
endmodule
